// [bench/scs_chk.sv]
// scs_chk.sv: bus and pin relations of the serial port top.
// assumes: bound to scs_top; one clock, synchronous reset.
`timescale 1ns/10ps
module scs_chk (
  // clock and reset
  input logic        aclk,
  input logic        aresetn,
  // bus
  input logic [11:0] s_axi_araddr,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic [1:0]  s_axi_bresp,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  // pins and levels
  input logic        txd_o,
  input logic        txd_oe,
  input logic        txd_serial,
  input logic        standby_req,
  input logic        tx_empty_irq,
  input logic        rx_full_irq,
  input logic        rx_error_irq,
  input logic        tx_done_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_tx_pin_func: assert property (
    !txd_serial |-> txd_o && !txd_oe) else $error("tx pin function split");
  a_b_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_aw_low: assert property (
    s_axi_awvalid && s_axi_awready |=> !s_axi_awready)
    else $error("address ready while busy");
  a_b_bound: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  a_unmapped_err: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr >= 12'h018 |=> s_axi_rresp == 2'b10)
    else $error("unmapped read not refused");
  a_rd_upper: assert property (s_axi_arvalid && s_axi_arready &&
    s_axi_araddr == 12'h004 |=> s_axi_rdata[31:8] == 24'h00_0000)
    else $error("status upper bits set");
  a_standby_quiet: assert property (
    standby_req |-> ##2 !(tx_empty_irq || rx_full_irq ||
    rx_error_irq || tx_done_irq)) else $error("irq after standby");
  a_tx_start_len: assert property (
    txd_oe && $fell(txd_o) |-> !txd_o [*8])
    else $error("low bit too short");
endmodule // scs_chk

// [bench/scs_remote.sv]
// scs_remote.sv: remote async station driving the receive pins.
// assumes: receiver uses external clock, sixteen clocks a bit.
`timescale 1ns/10ps
module scs_remote (
  // link
  output logic rxd_i,
  output logic sck_i
);
  initial begin
    rxd_i = 1'b1;
    sck_i = 1'b1;
  end
  // sixteen clocks a bit
  // clock stands still between frames, line idles at mark
  task automatic send(input logic [7:0] d, input logic mp_on,
                      input logic mpb);
    logic [10:0] f;
    f = mp_on ? {1'b1, mpb, d, 1'b0} : {2'b11, d, 1'b0};
    #7;
    for (int i = 0; i < 12; i++) begin
      rxd_i = (i < 11) ? f[i] : 1'b1;
      repeat (16) begin
        #160 sck_i = 1'b0;
        #160 sck_i = 1'b1;
      end
    end
  endtask
endmodule // scs_remote

// [bench/test_serial_ctrl_status.sv]
// test_serial_ctrl_status.sv: register level tests of the serial port.
// assumes: scs_top, scs_remote and scs_chk compiled before this file.
`timescale 1ns/10ps
`include "scs_regs.vh"
module test_serial_ctrl_status;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic [11:0] s_axi_araddr = 12'h000;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic        s_axi_bready = 1'b0, s_axi_arvalid = 1'b0;
  logic        s_axi_rready = 1'b0, standby_req = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, txd_o, txd_oe, sck_o, sck_oe, txd_serial;
  logic        rxd_serial, tx_empty_irq, rx_full_irq, rx_error_irq;
  logic        tx_done_irq, rxd_i, sck_i;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  int          err_total = 0;
  int          checked = 0;
  int          cyc = 0;

  always #20 aclk = ~aclk;

  scs_top dut_u (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .txd_o, .txd_oe, .rxd_i,
    .sck_i, .sck_o, .sck_oe, .txd_serial, .rxd_serial, .standby_req,
    .tx_empty_irq, .rx_full_irq, .rx_error_irq, .tx_done_irq);
  scs_remote rem_u (.rxd_i, .sck_i);

  // --------------------------------------------------------------
  // bus tasks
  // --------------------------------------------------------------
  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic pin(input string n, input logic e, input logic g);
    chk(n, 32'(e), 32'(g));
  endtask
  // ready is raised one cycle late so the response hold is exercised
  task automatic wr(input logic [11:0] a, input logic [31:0] d,
                    input logic [1:0] er = 2'b00);
    logic done;
    done = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        chk($sformatf("bresp %h", a), 32'(er), 32'(s_axi_bresp));
        s_axi_bready <= 1'b0;
        done = 1'b1;
      end else if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e,
                    input logic [1:0] er = 2'b00);
    logic done;
    done = 1'b0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!done) begin
      @(posedge aclk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid && s_axi_rready) begin
        chk($sformatf("rresp %h", a), 32'(er), 32'(s_axi_rresp));
        if (er == 2'b00) chk($sformatf("read %h", a), e, s_axi_rdata);
        s_axi_rready <= 1'b0;
        done = 1'b1;
      end else if (s_axi_rvalid) s_axi_rready <= 1'b1;
    end
  endtask
  // samples mid-bit; DIV 0 gives sixteen clocks a bit
  task automatic cap(input logic [7:0] e);
    logic [9:0] f;
    wait (txd_o === 1'b0);
    repeat (8) @(posedge aclk);
    for (int i = 0; i < 10; i++) begin
      if (i > 0) repeat (16) @(posedge aclk);
      f[i] = txd_o;
    end
    chk("tx frame", {22'h00_0000, 1'b1, e, 1'b0}, {22'h00_0000, f});
  endtask
  task automatic rx(input logic [7:0] d, input logic m, input logic b);
    rem_u.send(d, m, b);
    @(posedge aclk);
  endtask
  task automatic tally_and_finish;
    if (err_total == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // five received frames of ~1540 clocks dominate the run
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish;
    end
  end

  // --------------------------------------------------------------
  // scenarios
  // --------------------------------------------------------------
  initial begin
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(`SCS_OFF_CTRL, 32'h0000_0000);
    rd(`SCS_OFF_FLAGS, 32'h0000_0084);
    pin("txd_oe", 1'b0, txd_oe);
    rd(12'h020, 32'h0000_0000, 2'b10);
    wr(12'h020, 32'h0000_00FF, 2'b10);
    wr(`SCS_OFF_FLAGS, 32'h0000_00FF);
    rd(`SCS_OFF_FLAGS, 32'h0000_0085);
    wr(`SCS_OFF_FLAGS, 32'h0000_0000);
    rd(`SCS_OFF_FLAGS, 32'h0000_0084);
    wr(`SCS_OFF_FRAME, 32'h0000_0000);
    wr(`SCS_OFF_DIV, 32'h0000_0000);
    wr(`SCS_OFF_CTRL, 32'h0000_00A4);
    pin("txd_oe", 1'b1, txd_oe);
    pin("tx_empty_irq", 1'b1, tx_empty_irq);
    fork
      begin
        cap(8'h55);
        cap(8'hA3);
      end
      begin
        wr(`SCS_OFF_TXDATA, 32'h0000_0055);
        wr(`SCS_OFF_TXDATA, 32'h0000_00A3);
        rd(`SCS_OFF_FLAGS, 32'h0000_0000);
        pin("tx_empty_irq", 1'b0, tx_empty_irq);
        pin("tx_done_irq", 1'b0, tx_done_irq);
      end
    join
    repeat (16) @(posedge aclk);
    rd(`SCS_OFF_FLAGS, 32'h0000_0084);
    pin("tx_done_irq", 1'b1, tx_done_irq);
    wr(`SCS_OFF_FLAGS, 32'h0000_0080);
    rd(`SCS_OFF_FLAGS, 32'h0000_0084);
    wr(`SCS_OFF_CTRL, 32'h0000_0000);
    pin("tx_empty_irq", 1'b0, tx_empty_irq);
    rd(`SCS_OFF_FLAGS, 32'h0000_0084);
    for (int k = 0; k < 3; k++) begin
      wr(`SCS_OFF_CTRL, 32'(k));
      pin("sck_oe", k == 1, sck_oe);
    end
    wr(`SCS_OFF_CTRL, 32'h0000_0052);
    pin("rxd_serial", 1'b1, rxd_serial);
    rx(8'h3C, 1'b0, 1'b0);
    rd(`SCS_OFF_FLAGS, 32'h0000_00C4);
    pin("rx_full_irq", 1'b1, rx_full_irq);
    rx(8'h99, 1'b0, 1'b0);
    rd(`SCS_OFF_FLAGS, 32'h0000_00E4);
    rd(`SCS_OFF_RXDATA, 32'h0000_003C);
    pin("rx_error_irq", 1'b1, rx_error_irq);
    wr(`SCS_OFF_CTRL, 32'h0000_0002);
    pin("rxd_serial", 1'b0, rxd_serial);
    rd(`SCS_OFF_FLAGS, 32'h0000_00A4);
    wr(`SCS_OFF_FLAGS, 32'h0000_0084);
    rd(`SCS_OFF_FLAGS, 32'h0000_0084);
    wr(`SCS_OFF_CTRL, 32'h0000_005A);
    rx(8'h11, 1'b0, 1'b0);
    rd(`SCS_OFF_FLAGS, 32'h0000_00C4);
    rd(`SCS_OFF_RXDATA, 32'h0000_0011);
    wr(`SCS_OFF_FRAME, 32'h0000_0004);
    rx(8'h44, 1'b1, 1'b0);
    rd(`SCS_OFF_FLAGS, 32'h0000_0084);
    pin("rx_full_irq", 1'b0, rx_full_irq);
    rx(8'h22, 1'b1, 1'b1);
    rd(`SCS_OFF_FLAGS, 32'h0000_00C6);
    rd(`SCS_OFF_CTRL, 32'h0000_0052);
    rd(`SCS_OFF_RXDATA, 32'h0000_0022);
    standby_req <= 1'b1;
    @(posedge aclk);
    standby_req <= 1'b0;
    @(posedge aclk);
    rd(`SCS_OFF_CTRL, 32'h0000_0000);
    rd(`SCS_OFF_FLAGS, 32'h0000_0084);
    tally_and_finish;
  end
endmodule // test_serial_ctrl_status

bind scs_top scs_chk chk_u (.aclk, .aresetn, .s_axi_araddr,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
  .s_axi_rvalid, .s_axi_rready, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .txd_o, .txd_oe, .txd_serial, .standby_req,
  .tx_empty_irq, .rx_full_irq, .rx_error_irq, .tx_done_irq);

// [core/scs_regs.vh]
// scs_regs.vh: offsets, fields, reset values and timing of the serial
// control and status block.
// assumes: included by the top design file of the block and by the test, by bare name
`ifndef SCS_REGS_VH
`define SCS_REGS_VH

// -----------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------
`define SCS_OFF_CTRL   12'h000
`define SCS_OFF_FLAGS  12'h004
`define SCS_OFF_TXDATA 12'h008
`define SCS_OFF_RXDATA 12'h00C
`define SCS_OFF_FRAME  12'h010
`define SCS_OFF_DIV    12'h014

// -----------------------------------------------------------------
// control register fields
// -----------------------------------------------------------------
`define SCS_C_TXIRQ 7
`define SCS_C_RXIRQ 6
`define SCS_C_TXON  5
`define SCS_C_RXON  4
`define SCS_C_WAKE  3
`define SCS_C_DNIRQ 2
`define SCS_C_CK1  1
`define SCS_C_CK0  0

// -----------------------------------------------------------------
// status register fields
// -----------------------------------------------------------------
`define SCS_S_TDE  7
`define SCS_S_RDF  6
`define SCS_S_OVR  5
`define SCS_S_FRM  4
`define SCS_S_PAR  3
`define SCS_S_TND  2
`define SCS_S_RAB  1
`define SCS_S_TAB  0

// -----------------------------------------------------------------
// frame register fields
// -----------------------------------------------------------------
`define SCS_F_SYNC 7
`define SCS_F_PE   5
`define SCS_F_PM   4
`define SCS_F_AWM  2

// -----------------------------------------------------------------
// reset values and timing
// -----------------------------------------------------------------
`define SCS_CTRL_RST  8'h00
`define SCS_FLAGS_RST 8'h84
`define SCS_FRAME_RST 8'h00
`define SCS_DIV_RST   16'h0000
`define SCS_OVS       16
`define SCS_OVS_W     4

`endif

// [core/scs_sync2.v]
// scs_sync2.v: two flip-flop synchroniser for one pin level.
// assumes: input is asynchronous to aclk.
`timescale 1ns/10ps
module scs_sync2 (
  // clock and reset
  input  wire aclk,
  input  wire aresetn,
  // level
  input  wire din,
  output reg  dout
);
  reg meta_q;

  // first stage feeds only the second
  always @(posedge aclk) begin
    if (!aresetn) begin
      meta_q <= 1'b1;
      dout   <= 1'b1;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end
endmodule // scs_sync2

// [core/scs_tick.v]
// scs_tick.v: oversample tick generator, one pulse per div+1 clocks.
// assumes: div is a stable software value on aclk.
`timescale 1ns/10ps
module scs_tick (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // control
  input  wire        run,
  input  wire [15:0] div,
  output reg         tick
);
  reg [15:0] cnt_q;

  always @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end else if (cnt_q >= div) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick  <= 1'b0;
    end
  end
endmodule // scs_tick

// [core/scs_top.v]
// scs_top.v: serial port control and status with AXI4-Lite registers.
// assumes: one AXI4-Lite master; pins come from outside the clock domain.
// How it works
// RQ1 - tx off holds empty flag, pin port
// RQ2 - tx data write clears empty, starts
// RQ3 - tx enable makes pin serial output
// RQ4 - software sets format before tx enable
// RQ5 - rx disable keeps receive flags
// RQ6 - rx starts on start bit or clock
// RQ7 - rx enable makes pin serial input
// RQ8 - address wake only async with mode
// RQ9 - address wake suppresses receive results
// RQ10 - address char sets bit, ends wake
// RQ11 - tx end interrupt when nothing queued
// RQ12 - clock select bits choose source, pin
// RQ13 - async clock output at bit rate
// RQ14 - external async clock is sixteen times
// RQ15 - software keeps low select bit zero
// RQ16 - clock select before frame mode
// RQ17 - status resets to 84 hex
// RQ18 - flags clear by zero after one read
// RQ19 - done, received address bits read-only
// RQ20 - empty flag sets on move or disable
// RQ21 - tx empty irq drops with flag, enable
// RQ22 - overrun when full at completion
// RQ23 - each irq is enable and flag
//
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`include "scs_regs.vh"
module scs_top (
  // clock and reset
  input  wire        aclk,
  input  wire        aresetn,
  // axi4-lite write
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  // axi4-lite read
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  // serial pins
  output reg         txd_o,
  output reg         txd_oe,
  input  wire        rxd_i,
  input  wire        sck_i,
  output reg         sck_o,
  output reg         sck_oe,
  output reg         txd_serial,
  output reg         rxd_serial,
  // power modes
  input  wire        standby_req,
  // interrupt levels
  output reg         tx_empty_irq,
  output reg         rx_full_irq,
  output reg         rx_error_irq,
  output reg         tx_done_irq
);
  localparam TX_IDLE = 2'd0;
  localparam TX_SHFT = 2'd1;
  localparam RX_IDLE = 2'd0;
  localparam RX_SHFT = 2'd1;

  reg  [7:0]  ctrl_q, flags_q, frame_q, txh_q, rxh_q, txs_q, rxs_q;
  reg  [15:0] div_q;
  reg  [7:0]  seen_q;
  reg  [1:0]  txst_q, rxst_q;
  reg  [3:0]  txbit_q, rxbit_q;
  reg  [3:0]  txph_q, rxph_q;
  reg         txpar_q, rxpar_q, rxmp_q;
  reg         aw_hold_q, w_hold_q;
  reg  [11:0] awaddr_q;
  reg  [31:0] wdata_q;
  reg  [3:0]  wstrb_q;
  reg         sck_d1_q;
  wire        rxd_s, sck_s, itick;
  wire        ext_clk = ctrl_q[`SCS_C_CK1];
  wire        sync_m  = frame_q[`SCS_F_SYNC];
  wire        awm     = frame_q[`SCS_F_AWM];
  // RQ8 wake gating
  wire        wake_on = ctrl_q[`SCS_C_WAKE] & awm & ~sync_m;
  wire        ext_rise = sck_s & ~sck_d1_q;
  // RQ14 sixteen external edges per bit
  wire        otick = ext_clk ? ext_rise : itick;
  wire        tx_en = ctrl_q[`SCS_C_TXON];
  wire        rx_en = ctrl_q[`SCS_C_RXON];

  scs_sync2 u_rxd (.aclk(aclk), .aresetn(aresetn), .din(rxd_i),
                   .dout(rxd_s));
  scs_sync2 u_sck (.aclk(aclk), .aresetn(aresetn), .din(sck_i),
                   .dout(sck_s));
  scs_tick  u_tick (.aclk(aclk), .aresetn(aresetn), .run(tx_en | rx_en),
                    .div(div_q), .tick(itick));

  // -----------------------------------------------------------------
  // bus slave
  // -----------------------------------------------------------------
  wire wr_go = aw_hold_q & w_hold_q & ~s_axi_bvalid;
  wire rd_go = s_axi_arvalid & s_axi_arready;
  wire wr_ctl = wr_go & (awaddr_q == `SCS_OFF_CTRL) & wstrb_q[0];
  wire wr_flg = wr_go & (awaddr_q == `SCS_OFF_FLAGS) & wstrb_q[0];
  wire wr_txd = wr_go & (awaddr_q == `SCS_OFF_TXDATA) & wstrb_q[0];
  wire wr_frm = wr_go & (awaddr_q == `SCS_OFF_FRAME) & wstrb_q[0];
  wire wr_div = wr_go & (awaddr_q == `SCS_OFF_DIV);
  wire rd_flg = rd_go & (s_axi_araddr == `SCS_OFF_FLAGS);
  wire rd_rxd = rd_go & (s_axi_araddr == `SCS_OFF_RXDATA);
  reg  [31:0] rdat;
  reg         rerr, werr;

  always @* begin
    rerr = 1'b0;
    if (s_axi_araddr == `SCS_OFF_CTRL) begin
      rdat = {24'h00_0000, ctrl_q};
    end else if (s_axi_araddr == `SCS_OFF_FLAGS) begin
      rdat = {24'h00_0000, flags_q};
    end else if (s_axi_araddr == `SCS_OFF_TXDATA) begin
      rdat = {24'h00_0000, txh_q};
    end else if (s_axi_araddr == `SCS_OFF_RXDATA) begin
      rdat = {24'h00_0000, rxh_q};
    end else if (s_axi_araddr == `SCS_OFF_FRAME) begin
      rdat = {24'h00_0000, frame_q};
    end else if (s_axi_araddr == `SCS_OFF_DIV) begin
      rdat = {16'h0000, div_q};
    end else begin
      rdat = 32'h0000_0000;
      rerr = 1'b1;
    end
  end

  always @* begin
    werr = ~((awaddr_q == `SCS_OFF_CTRL) | (awaddr_q == `SCS_OFF_FLAGS) |
             (awaddr_q == `SCS_OFF_TXDATA) | (awaddr_q == `SCS_OFF_RXDATA) |
             (awaddr_q == `SCS_OFF_FRAME) | (awaddr_q == `SCS_OFF_DIV));
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= 2'b00;
      s_axi_rdata   <= 32'h0000_0000;
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      awaddr_q      <= 12'h000;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_hold_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_hold_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= werr ? 2'b10 : 2'b00;
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
      end
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= rdat;
        s_axi_rresp   <= rerr ? 2'b10 : 2'b00;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // transmitter
  // -----------------------------------------------------------------
  wire [3:0] tx_last = sync_m ? 4'd7 : (4'd8 + {3'd0, frame_q[`SCS_F_PE]}
                       + {3'd0, awm});
  wire tx_load = (txst_q == TX_IDLE) & tx_en & ~flags_q[`SCS_S_TDE];
  wire tx_step = (txst_q == TX_SHFT) & otick & (txph_q == 4'hF);
  wire tx_fin  = tx_step & (txbit_q == tx_last + 4'd1);
  // next character fetched at frame end; none queued means done
  wire tx_more = tx_fin & tx_en & ~flags_q[`SCS_S_TDE];

  always @(posedge aclk) begin
    if (!aresetn || standby_req) begin
      txst_q  <= TX_IDLE;
      txs_q   <= 8'h00;
      txbit_q <= 4'h0;
      txph_q  <= 4'h0;
      txpar_q <= 1'b0;
      txd_o   <= 1'b1;
    end else if (tx_load | tx_more) begin
      txst_q  <= TX_SHFT;
      txs_q   <= txh_q;
      txbit_q <= 4'h0;
      txph_q  <= 4'h0;
      txpar_q <= frame_q[`SCS_F_PM];
      txd_o   <= sync_m ? txh_q[0] : 1'b0;
    end else if (tx_fin | ~tx_en) begin
      txst_q <= TX_IDLE;
      txd_o  <= 1'b1;
    end else if ((txst_q == TX_SHFT) & otick) begin
      txph_q <= txph_q + 4'h1;
      if (tx_step) begin
        txbit_q <= txbit_q + 4'h1;
        txs_q   <= {1'b1, txs_q[7:1]};
        txpar_q <= txpar_q ^ txs_q[0];
        // sync puts bit 0 out at load, async the start bit
        if (sync_m) begin
          txd_o <= (txbit_q < 4'h7) ? txs_q[1] : 1'b1;
        end else if (txbit_q < 4'h8) begin
          txd_o <= txs_q[0];
        end else if (frame_q[`SCS_F_PE] && txbit_q == 4'h8) begin
          txd_o <= txpar_q;
        end else if (awm && txbit_q == 4'h8 + {3'd0, frame_q[`SCS_F_PE]})
        begin
          txd_o <= flags_q[`SCS_S_TAB];
        end else begin
          txd_o <= 1'b1;
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // receiver
  // -----------------------------------------------------------------
  // index 0 is the start bit, so the stop bit sits one past the data
  wire [3:0] rx_last = sync_m ? 4'd7 : (4'd9 + {3'd0, frame_q[`SCS_F_PE]}
                       + {3'd0, awm});
  wire rx_blk = flags_q[`SCS_S_OVR] | flags_q[`SCS_S_FRM] |
                flags_q[`SCS_S_PAR];
  // RQ6 start bit or clock starts reception
  wire rx_start = (rxst_q == RX_IDLE) & rx_en & ~rx_blk &
                  (sync_m ? ext_rise : ~rxd_s);
  wire rx_samp = (rxst_q == RX_SHFT) & otick & (rxph_q == 4'h7);
  wire rx_done = rx_samp & (rxbit_q == rx_last);
  wire rx_mpb  = awm ? rxd_s : 1'b0;
  wire rx_stop_bad = ~sync_m & ~rxd_s;
  wire rx_par_bad  = ~sync_m & frame_q[`SCS_F_PE] &
                     (rxpar_q != frame_q[`SCS_F_PM]);

  always @(posedge aclk) begin
    if (!aresetn || standby_req) begin
      rxst_q  <= RX_IDLE;
      rxs_q   <= 8'h00;
      rxbit_q <= 4'h0;
      rxph_q  <= 4'h0;
      rxpar_q <= 1'b0;
      rxmp_q  <= 1'b0;
    end else if (rx_start) begin
      rxst_q  <= RX_SHFT;
      rxbit_q <= 4'h0;
      rxph_q  <= 4'h0;
      rxpar_q <= 1'b0;
      // no address bit carried over from the last frame
      rxmp_q  <= 1'b0;
    end else if (rx_done | ~rx_en) begin
      rxst_q <= RX_IDLE;
    end else if ((rxst_q == RX_SHFT) & otick) begin
      rxph_q <= rxph_q + 4'h1;
      if (rx_samp) begin
        rxbit_q <= rxbit_q + 4'h1;
        if (rxbit_q >= 4'd1 && rxbit_q <= 4'd8) begin
          rxs_q <= {rxd_s, rxs_q[7:1]};
        end
        if (rxbit_q >= 4'd1 && rxbit_q <= 4'd9) begin
          rxpar_q <= rxpar_q ^ rxd_s;
        end
        if (rxbit_q == 4'd9 + {3'd0, frame_q[`SCS_F_PE]}) begin
          rxmp_q <= rx_mpb;
        end
      end
    end
  end

  // -----------------------------------------------------------------
  // control, frame and flags
  // -----------------------------------------------------------------
  wire [7:0] wb = wdata_q[7:0];
  // RQ9 results withheld during wake
  wire rx_take = rx_done & ~(wake_on & ~rxmp_q);
  // RQ10 address char ends wake
  wire rx_addr = rx_done & wake_on & rxmp_q;

  always @(posedge aclk) begin
    if (!aresetn || standby_req) begin
      ctrl_q  <= `SCS_CTRL_RST;
      frame_q <= `SCS_FRAME_RST;
      div_q   <= `SCS_DIV_RST;
      // RQ17 status reset value
      flags_q <= `SCS_FLAGS_RST;
      seen_q  <= 8'h00;
      txh_q   <= 8'h00;
      rxh_q   <= 8'h00;
    end else begin
      if (wr_ctl) begin
        ctrl_q <= wb;
      end
      if (rx_addr) begin
        ctrl_q[`SCS_C_WAKE] <= 1'b0;
      end
      if (wr_frm) begin
        frame_q <= wb;
      end
      if (wr_div) begin
        div_q <= wdata_q[15:0];
      end
      if (rd_flg) begin
        seen_q <= flags_q;
      end
      // RQ18 zero after read clears, one keeps
      if (wr_flg) begin
        flags_q[7:3] <= flags_q[7:3] & ~(seen_q[7:3] & ~wb[7:3]);
        // RQ19 done and received bits kept
        flags_q[`SCS_S_TAB] <= wb[`SCS_S_TAB];
        seen_q <= 8'h00;
      end
      if (rd_rxd) begin
        flags_q[`SCS_S_RDF] <= 1'b0;
      end
      // RQ2 data write clears empty
      if (wr_txd) begin
        txh_q <= wb;
        flags_q[`SCS_S_TDE] <= 1'b0;
        flags_q[`SCS_S_TND] <= 1'b0;
      end
      // RQ20 set on move to shifter
      if (tx_load | tx_more) begin
        flags_q[`SCS_S_TDE] <= 1'b1;
      end
      // RQ11 done when nothing queued
      if (tx_fin & ~tx_more) begin
        flags_q[`SCS_S_TND] <= 1'b1;
      end
      // RQ1 held set while tx off
      if (~tx_en) begin
        flags_q[`SCS_S_TDE] <= 1'b1;
      end
      // RQ5 receive flags change only on events
      if (rx_take) begin
        if (flags_q[`SCS_S_RDF]) begin
          // RQ22 overrun keeps old data
          flags_q[`SCS_S_OVR] <= 1'b1;
        end else begin
          rxh_q <= rxs_q;
          flags_q[`SCS_S_FRM] <= rx_stop_bad;
          flags_q[`SCS_S_PAR] <= rx_par_bad;
          flags_q[`SCS_S_RDF] <= ~rx_stop_bad & ~rx_par_bad;
        end
        flags_q[`SCS_S_RAB] <= rxmp_q;
      end
      if (rx_addr) begin
        flags_q[`SCS_S_RAB] <= 1'b1;
      end
    end
  end

  // -----------------------------------------------------------------
  // pins and interrupt levels
  // -----------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      // pin idles high: no false edge right after reset
      sck_d1_q     <= 1'b1;
      txd_oe       <= 1'b0;
      txd_serial   <= 1'b0;
      rxd_serial   <= 1'b0;
      sck_o        <= 1'b0;
      sck_oe       <= 1'b0;
      tx_empty_irq <= 1'b0;
      rx_full_irq  <= 1'b0;
      rx_error_irq <= 1'b0;
      tx_done_irq  <= 1'b0;
    end else begin
      sck_d1_q <= sck_s;
      // RQ3 serial output when enabled
      txd_oe     <= tx_en;
      txd_serial <= tx_en;
      // RQ7 serial input when enabled
      rxd_serial <= rx_en;
      // RQ12 clock pin function
      sck_oe <= ~ext_clk & (sync_m | ctrl_q[`SCS_C_CK0]);
      // RQ13 bit rate clock, high in second half
      sck_o  <= txph_q[3] | rxph_q[3];
      // RQ21 RQ23 enable and flag
      tx_empty_irq <= ctrl_q[`SCS_C_TXIRQ] & flags_q[`SCS_S_TDE];
      rx_full_irq  <= ctrl_q[`SCS_C_RXIRQ] & flags_q[`SCS_S_RDF];
      rx_error_irq <= ctrl_q[`SCS_C_RXIRQ] & rx_blk;
      tx_done_irq  <= ctrl_q[`SCS_C_DNIRQ] & flags_q[`SCS_S_TND];
    end
  end
endmodule // scs_top
